// ===== src/async_timer_prescaler_waveform_ctrl.v
// Timer source select, prescaler, waveform mode and compare outputs with APB registers
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "timer_map.vh"
module async_timer_prescaler_waveform_ctrl (
    input  wire                pclk,              // APB clock, 100 MHz
    input  wire                presetn,           // Async reset, active low
    input  wire                psel,              // APB select
    input  wire                penable,           // APB access phase
    input  wire                pwrite,            // APB direction
    input  wire [`ADDR_W-1:0]  paddr,             // APB byte address
    input  wire [31:0]         pwdata,            // APB write data
    output wire                pready,            // APB ready
    output reg  [31:0]         prdata,            // APB read data
    output wire                pslverr,           // APB error, unmapped address
    input  wire                osc_pin_in,        // Oscillator input pin
    output wire                osc_port_detach,   // Oscillator pins leave port
    output wire                crystal_osc_en,    // Crystal oscillator running
    output wire                compare_out_a,     // Compare output A level
    output wire                compare_out_a_en,  // Output A overrides port
    output wire                compare_out_b,     // Compare output B level
    output wire                compare_out_b_en,  // Output B overrides port
    output wire                overflow_flag      // Sticky overflow flag
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg  [7:0] ctrl_reg_a;           // Output modes, waveform low bits
    reg  [7:0] ctrl_reg_b;           // Waveform bit 2, clock select
    reg  [7:0] async_status_reg;     // Source select bits
    reg  [7:0] counter_value;        // Timer count
    reg  [7:0] cmp_buf_a;            // Compare A as written
    reg  [7:0] cmp_buf_b;            // Compare B as written
    reg  [7:0] compare_value_a;      // Compare A in use
    reg  [7:0] compare_value_b;      // Compare B in use
    reg        ovf_reg;              // Overflow flag
    reg        up_reg;               // Phase-correct direction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire       setup    = psel & ~penable;              // Setup phase
    wire       access   = psel & penable;               // Access phase
    wire       wr       = access & pwrite;              // Write commits
    wire [7:0] wbyte    = pwdata[7:0];                  // Register byte
    wire       aligned  = (paddr[1:0] == 2'h0);         // Word aligned
    wire [9:0] widx     = paddr[`ADDR_W-1:2];           // Register index

    wire hit_a   = aligned & (widx == {2'h0, `IDX_CTRL_A});
    wire hit_b   = aligned & (widx == {2'h0, `IDX_CTRL_B});
    wire hit_cnt = aligned & (widx == {2'h0, `IDX_COUNTER});
    wire hit_ca  = aligned & (widx == {2'h0, `IDX_CMP_A});
    wire hit_cb  = aligned & (widx == {2'h0, `IDX_CMP_B});
    wire hit_as  = aligned & (widx == {2'h0, `IDX_ASYNC_STATUS});
    wire hit_gc  = aligned & (widx == {2'h0, `IDX_GEN_CTRL});
    wire hit_fl  = aligned & (widx == {2'h0, `IDX_FLAGS});
    wire mapped  = hit_a | hit_b | hit_cnt | hit_ca | hit_cb | hit_as | hit_gc | hit_fl;

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ----------------------------------------
    // Source clock selection
    // ----------------------------------------
    wire async_sel = async_status_reg[`AS_ASYNC_SEL];   // Async clocking
    wire ext_clk   = async_status_reg[`AS_EXT_CLK];     // External clock in

    reg  osc_meta_reg;               // Synchroniser first stage
    reg  osc_sync_reg;               // Synchroniser second stage
    reg  osc_prev_reg;               // Previous synchronised level

    // Pin is foreign to pclk, so two flops before any use
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_pin_in;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    // Each rising edge of the pin is one source period; limits pin rate to well under pclk/4
    wire osc_rise = osc_sync_reg & ~osc_prev_reg;
    wire src_tick = async_sel ? osc_rise : 1'b1;

    // Pins leave the port while async clocking is on
    assign osc_port_detach = async_sel;
    // Crystal amplifier only runs without external clock input
    assign crystal_osc_en  = async_sel & ~ext_clk;

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Self-clearing strobe, never stored
    wire presc_clear = wr & hit_gc & wbyte[`GC_PRESC_RST];
    wire tick;                       // Counter enable from the tap

    timer_prescaler u_presc (
        .pclk        (pclk),
        .presetn     (presetn),
        .src_tick    (src_tick),
        .presc_clear (presc_clear),
        .clk_sel     (ctrl_reg_b[`CB_CS_HI:0]),
        .count_en    (tick)
    );

    // ----------------------------------------
    // Waveform mode decode
    // ----------------------------------------
    wire [2:0] waveform_mode = {ctrl_reg_b[`CB_WGM2], ctrl_reg_a[1:0]};
    wire is_fast  = (waveform_mode == `WGM_FAST_FF) | (waveform_mode == `WGM_FAST_A);
    wire is_pc    = (waveform_mode == `WGM_PC_FF) | (waveform_mode == `WGM_PC_A);
    wire top_is_a = (waveform_mode == `WGM_CTC) | (waveform_mode == `WGM_PC_A) |
                    (waveform_mode == `WGM_FAST_A);
    // Reserved modes 4 and 6 fall through to free counting with TOP at MAX
    wire [7:0] top = top_is_a ? compare_value_a : `MAX_VAL;
    wire [1:0] cls = is_fast ? `CLS_FAST : (is_pc ? `CLS_PC : `CLS_NONPWM);

    wire at_top    = tick & (counter_value == top);
    wire at_bottom = tick & (counter_value == `BOTTOM_VAL);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Software write wins over counting in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value <= `RESET_BYTE;
            up_reg        <= 1'b1;
        end else if (wr && hit_cnt) begin
            counter_value <= wbyte;
        end else if (tick) begin
            if (is_pc) begin
                if (up_reg && counter_value == top) begin
                    up_reg        <= 1'b0;
                    counter_value <= counter_value - 1'b1;
                end else if (up_reg) begin
                    counter_value <= counter_value + 1'b1;
                end else if (counter_value == `BOTTOM_VAL) begin
                    up_reg        <= 1'b1;
                    counter_value <= counter_value + 1'b1;
                end else begin
                    counter_value <= counter_value - 1'b1;
                end
            end else begin
                up_reg        <= 1'b1;
                // Normal wraps at MAX, CLEAR_ON_MATCH_MODE and fast PWM at TOP
                counter_value <= (counter_value == top) ? `BOTTOM_VAL : counter_value + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Compare value buffering
    // ----------------------------------------
    // Double buffering keeps PWM periods glitch free
    wire cmp_load = is_pc ? at_top : (is_fast ? at_top : 1'b1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_buf_a       <= `RESET_BYTE;
            cmp_buf_b       <= `RESET_BYTE;
            compare_value_a <= `RESET_BYTE;
            compare_value_b <= `RESET_BYTE;
        end else begin
            if (wr && hit_ca)
                cmp_buf_a <= wbyte;
            if (wr && hit_cb)
                cmp_buf_b <= wbyte;
            // Fast PWM loads on the wrap to BOTTOM, phase-correct at TOP
            if (cmp_load) begin
                compare_value_a <= cmp_buf_a;
                compare_value_b <= cmp_buf_b;
            end
        end
    end

    // ----------------------------------------
    // Overflow flag
    // ----------------------------------------
    wire ovf_event = is_pc ? (at_bottom & ~up_reg) :
                     (waveform_mode == `WGM_FAST_A) ? at_top :
                     (tick & (counter_value == `MAX_VAL));
    wire ovf_clear = wr & hit_fl & wbyte[`FL_OVF];  // Write one clears

    // A new event in the clearing cycle is kept
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ovf_reg <= 1'b0;
        else if (ovf_event)
            ovf_reg <= 1'b1;
        else if (ovf_clear)
            ovf_reg <= 1'b0;
    end

    assign overflow_flag = ovf_reg;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg_a       <= `RESET_BYTE;
            ctrl_reg_b       <= `RESET_BYTE;
            async_status_reg <= `RESET_BYTE;
        end else if (wr) begin
            if (hit_a)
                ctrl_reg_a <= wbyte & `CA_RW_MASK;
            if (hit_b)
                ctrl_reg_b <= wbyte & `CB_RW_MASK;
            if (hit_as)
                async_status_reg <= wbyte & `AS_RW_MASK;
        end
    end

    // ----------------------------------------
    // Compare output channels
    // ----------------------------------------
    // Channel A may toggle in PWM when bit 2 is set; channel B may not
    compare_out_unit #(
        .TOGGLE_IN_PWM (1)
    ) u_cmp_a (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (tick),
        .cnt       (counter_value),
        .cmp       (compare_value_a),
        .top       (top),
        .cls       (cls),
        .com       (ctrl_reg_a[`CA_COM_A_HI:`CA_COM_A_LO]),
        .wgm2      (waveform_mode[2]),
        .up        (up_reg),
        .out_reg   (compare_out_a),
        .connected (compare_out_a_en)
    );

    compare_out_unit #(
        .TOGGLE_IN_PWM (0)
    ) u_cmp_b (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (tick),
        .cnt       (counter_value),
        .cmp       (compare_value_b),
        .top       (top),
        .cls       (cls),
        .com       (ctrl_reg_a[`CA_COM_B_HI:`CA_COM_B_LO]),
        .wgm2      (waveform_mode[2]),
        .up        (up_reg),
        .out_reg   (compare_out_b),
        .connected (compare_out_b_en)
    );
    // Pin driver still needs its direction bit set outside this block

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg [7:0] rbyte;                 // Selected register byte

    // Write-only strobes and reserved bits read as zero
    always @* begin
        rbyte = `RESET_BYTE;
        if (hit_a)
            rbyte = ctrl_reg_a & `CA_RW_MASK;
        else if (hit_b)
            rbyte = ctrl_reg_b;
        else if (hit_cnt)
            rbyte = counter_value;
        else if (hit_ca)
            rbyte = cmp_buf_a;
        else if (hit_cb)
            rbyte = cmp_buf_b;
        else if (hit_as)
            rbyte = async_status_reg;
        else if (hit_fl)
            rbyte = {7'h00, ovf_reg};
    end

    // Captured in setup so the access cycle sees a flopped value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup)
            prdata <= {24'h00_0000, rbyte};
    end

endmodule

// ===== src/timer_map.vh
// Register map, field positions and constants of the timer source/prescaler/waveform block
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// Register indices; byte address is four times the index
`define IDX_CTRL_A        8'hB0
`define IDX_CTRL_B        8'hB1
`define IDX_COUNTER       8'hB2
`define IDX_CMP_A         8'hB3
`define IDX_CMP_B         8'hB4
`define IDX_ASYNC_STATUS  8'hB6
`define IDX_GEN_CTRL      8'hB8
`define IDX_FLAGS         8'hB9
`define ADDR_W            12

// Control register A fields
`define CA_COM_A_HI       7
`define CA_COM_A_LO       6
`define CA_COM_B_HI       5
`define CA_COM_B_LO       4
`define CA_RW_MASK        8'hF3
// Control register B fields
`define CB_WGM2           3
`define CB_CS_HI          2
`define CB_RW_MASK        8'h0F
// Async status fields
`define AS_EXT_CLK        6
`define AS_ASYNC_SEL      5
`define AS_RW_MASK        8'h60
// General timer control: prescaler reset bit
`define GC_PRESC_RST      1
// Flag register: overflow flag bit
`define FL_OVF            0

`define RESET_BYTE        8'h00
`define MAX_VAL           8'hFF
`define BOTTOM_VAL        8'h00

// Waveform mode codes
`define WGM_NORMAL        3'h0
`define WGM_PC_FF         3'h1
`define WGM_CTC           3'h2
`define WGM_FAST_FF       3'h3
`define WGM_PC_A          3'h5
`define WGM_FAST_A        3'h7

// Waveform classes handed to each compare output unit
`define CLS_NONPWM        2'h0
`define CLS_FAST          2'h1
`define CLS_PC            2'h2

// Compare output mode codes
`define COM_OFF           2'h0
`define COM_TOGGLE        2'h1
`define COM_CLEAR         2'h2
`define COM_SET           2'h3

// Prescaler geometry
`define PRESC_W           10

`endif

// ===== src/timer_prescaler.v
// Free-running source-clock prescaler with selectable tap
`timescale 1ns/1ps
`include "timer_map.vh"
module timer_prescaler (
    input  wire       pclk,        // System clock
    input  wire       presetn,     // Async reset, active low
    input  wire       src_tick,    // One source-clock period elapsed
    input  wire       presc_clear, // Prescaler reset pulse
    input  wire [2:0] clk_sel,     // Clock select field
    output reg        count_en     // One-cycle count enable
);

    // ----------------------------------------
    // Division counter
    // ----------------------------------------
    reg  [`PRESC_W-1:0] div_reg;   // Counts source ticks

    // Free running; a clear restarts phase so taps become predictable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= {`PRESC_W{1'b0}};
        end else if (presc_clear) begin
            div_reg <= {`PRESC_W{1'b0}};
        end else if (src_tick) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // Tap selection
    // ----------------------------------------
    // Tap fires on the tick that completes a full ratio of source periods
    always @* begin
        case (clk_sel)
            3'h0:    count_en = 1'b0;            // Stopped
            3'h1:    count_en = src_tick;
            3'h2:    count_en = src_tick & (&div_reg[2:0]);
            3'h3:    count_en = src_tick & (&div_reg[4:0]);
            3'h4:    count_en = src_tick & (&div_reg[5:0]);
            3'h5:    count_en = src_tick & (&div_reg[6:0]);
            3'h6:    count_en = src_tick & (&div_reg[7:0]);
            default: count_en = src_tick & (&div_reg[9:0]);
        endcase
    end

endmodule

// ===== src/compare_out_unit.v
// One compare output channel: waveform action on match, TOP and BOTTOM
`timescale 1ns/1ps
`include "timer_map.vh"
module compare_out_unit #(
    parameter TOGGLE_IN_PWM = 1                  // Code 1 may toggle in PWM modes
) (
    input  wire       pclk,        // System clock
    input  wire       presetn,     // Async reset, active low
    input  wire       tick,        // Counter advances this cycle
    input  wire [7:0] cnt,         // Current counter value
    input  wire [7:0] cmp,         // Active compare value
    input  wire [7:0] top,         // Current TOP
    input  wire [1:0] cls,         // Waveform class
    input  wire [1:0] com,         // Compare output mode
    input  wire       wgm2,        // Waveform mode bit 2
    input  wire       up,          // Counting upward
    output reg        out_reg,     // Compare output level
    output wire       connected    // Output overrides port
);

    wire match    = tick & (cnt == cmp);         // Compare match
    wire at_top   = tick & (cnt == top);         // Counter at TOP
    wire special  = (cmp == top) & com[1];       // Match ignored case
    wire tog_ok   = (TOGGLE_IN_PWM != 0) & wgm2; // PWM toggle permitted
    reg  out_next;                               // Next output level

    // Port override as soon as any mode bit is set
    assign connected = |com;

    // ----------------------------------------
    // Output action
    // ----------------------------------------
    always @* begin
        out_next = out_reg;
        case (cls)
            `CLS_FAST: begin
                if (com == `COM_TOGGLE) begin
                    if (match && tog_ok)
                        out_next = ~out_reg;
                end else if (com[1]) begin
                    // Wrap to BOTTOM happens on the tick at TOP
                    if (at_top)
                        out_next = ~com[0];
                    else if (match && !special)
                        out_next = com[0];
                end
            end
            `CLS_PC: begin
                if (com == `COM_TOGGLE) begin
                    if (match && tog_ok)
                        out_next = ~out_reg;
                end else if (com[1]) begin
                    if (special) begin
                        // Level at TOP follows the down-count action
                        if (at_top)
                            out_next = ~com[0];
                    end else if (match) begin
                        out_next = up ? com[0] : ~com[0];
                    end
                end
            end
            default: begin
                if (match) begin
                    case (com)
                        `COM_TOGGLE: out_next = ~out_reg;
                        `COM_CLEAR:  out_next = 1'b0;
                        `COM_SET:    out_next = 1'b1;
                        default:     out_next = out_reg;
                    endcase
                end
            end
        endcase
    end

    // Output flip-flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            out_reg <= 1'b0;
        else
            out_reg <= out_next;
    end

endmodule

// ===== tb/timer_ctrl_chk.sv
// Checker for the register side effects of the timer control block
`timescale 1ns/1ps
module timer_ctrl_chk (
    input wire        pclk,             // Clock
    input wire        presetn,          // Reset, active low
    input wire        psel,             // Select
    input wire        penable,          // Access phase
    input wire        pwrite,           // Direction
    input wire [11:0] paddr,            // Byte address
    input wire [31:0] pwdata,           // Write data
    input wire [31:0] prdata,           // Read data
    input wire        osc_port_detach,  // Pins detached
    input wire        crystal_osc_en,   // Crystal runs
    input wire        compare_out_a_en, // A overrides
    input wire        compare_out_b_en, // B overrides
    input wire        overflow_flag     // Overflow
);
    // ----------------
    // Helpers
    // ----------------
    localparam logic [11:0] A_CA = 12'h2C0; // Control A
    localparam logic [11:0] A_AS = 12'h2D8; // Async status
    localparam logic [11:0] A_FL = 12'h2E4; // Flags
    wire wr = psel && penable && pwrite;  // Write commits
    wire wr_ca = wr && paddr == A_CA;     // Control A write
    wire wr_as = wr && paddr == A_AS;     // Async write
    wire clr_fl = wr && paddr == A_FL && pwdata[0]; // Flag clear
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_rd_ca;
        psel && penable && !pwrite && paddr == A_CA;
    endsequence
    // ----------------
    // Properties
    // ----------------
    a_reset_src: assert property ($rose(presetn) |-> !osc_port_detach && !compare_out_a_en)
        else $error("source or output not in reset state");
    a_detach_follow: assert property (wr_as |=> osc_port_detach == $past(pwdata[5]))
        else $error("detach does not follow select");
    a_detach_hold: assert property ($changed(osc_port_detach) |-> $past(wr_as))
        else $error("detach changed without write");
    a_crystal_follow: assert property (wr_as |=> crystal_osc_en == $past(pwdata[5] & ~pwdata[6]))
        else $error("crystal enable wrong");
    a_ena_follow: assert property (wr_ca |=> compare_out_a_en == $past(|pwdata[7:6]))
        else $error("output A enable wrong");
    a_ena_hold: assert property ($changed(compare_out_a_en) |-> $past(wr_ca))
        else $error("output A enable changed alone");
    a_enb_follow: assert property (wr_ca |=> compare_out_b_en == $past(|pwdata[5:4]))
        else $error("output B enable wrong");
    a_resv_zero: assert property (s_rd_ca |-> prdata[3:2] == 2'b00)
        else $error("reserved bits not zero");
    a_ovf_sticky: assert property ($fell(overflow_flag) |-> $past(clr_fl))
        else $error("overflow fell without clear");
endmodule

bind async_timer_prescaler_waveform_ctrl timer_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .osc_port_detach(osc_port_detach), .crystal_osc_en(crystal_osc_en), .compare_out_a_en(compare_out_a_en),
    .compare_out_b_en(compare_out_b_en), .overflow_flag(overflow_flag));

// ===== tb/async_timer_prescaler_waveform_ctrl_bench.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module async_timer_prescaler_waveform_ctrl_bench;
    logic        pclk, presetn, psel, penable, pwrite, osc_pin_in; // Drivers
    logic [11:0] paddr;                                 // Byte address
    logic [31:0] pwdata, prdata, d;                     // Data and capture
    logic        pready, pslverr, e, det, xen, oa, oae, ob, obe, ovf; // Outputs
    int          mismatches, num_checks, cyc, i;        // Counters
    localparam logic [11:0] RA [4] = '{12'h2C0, 12'h2C4, 12'h2D8, 12'h2E0}; // Readback places
    localparam logic [7:0]  RM [4] = '{8'hF3, 8'h0F, 8'h60, 8'h00};         // Readable bits
    // Rows: async, ctrl A, ctrl B, counter, wait/4, expected {ovf,a,b}
    localparam logic [47:0] ROWS [20] = '{
        48'h00500100_0A03, 48'h00A00100_0A00, 48'h00F00100_0A03, 48'h000001F0_0A07,
        48'h00A20100_0A00, 48'h00A301F8_0307, 48'h00F301F8_0304, 48'h00F30100_0A03,
        48'h00A10100_0A00, 48'h00A101F8_4407, 48'h00430100_0A03, 48'h00030900_0A07,
        48'h000000FF_0A03, 48'h000002F8_0A03, 48'h000002FD_0A07, 48'h000003FF_0603,
        48'h000003FF_0A07, 48'h200001FE_0A07, 48'h200001F0_0A03, 48'h600001FE_0A07};

    async_timer_prescaler_waveform_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .osc_pin_in(osc_pin_in), .osc_port_detach(det), .crystal_osc_en(xen), .compare_out_a(oa),
        .compare_out_a_en(oae), .compare_out_b(ob), .compare_out_b_en(obe), .overflow_flag(ovf));

    // ----------------
    // Clocks and watchdog
    // ----------------
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // Slow pin clock, phase unrelated to pclk
    initial begin
        osc_pin_in = 0;
        #3;
        forever #30 osc_pin_in = ~osc_pin_in;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end

    // ----------------
    // Tasks
    // ----------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; read data and error captured at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Stop, clear flag, configure, restart prescaler, run, then compare
    task automatic run_row(input logic [47:0] r);
        apb(1, 12'h2C4, 0);
        apb(1, 12'h2E4, 1);
        apb(1, 12'h2D8, r[47:40]);
        apb(1, 12'h2C0, r[39:32]);
        apb(1, 12'h2C8, r[23:16]);
        apb(1, 12'h2E0, 2);
        apb(1, 12'h2C4, r[31:24]);
        repeat (4 * r[15:8]) @(posedge pclk);
        #1;
        check("ovf", ovf, r[2]);
        check("out_a", oa, r[1]);
        check("out_b", ob, r[0]);
        check("detach", det, r[45]);
        check("crystal", xen, r[45] & ~r[46]);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        mismatches = 0;
        num_checks = 0;
        cyc = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        #1;
        check("detach_rst", det, 0);
        for (i = 0; i < 4; i++) begin
            apb(0, RA[i], 0);
            check("reset_val", d, 0);
            apb(1, RA[i], 32'hFFFFFFFF);
            apb(0, RA[i], 0);
            check("readback", d, RM[i]);
        end
        // Every mode code on both channels
        for (i = 0; i < 4; i++) begin
            apb(1, 12'h2C0, i * 80);
            #1;
            // Enables only; the pin direction bit is software's job
            check("en_a", oae, i != 0);
            check("en_b", obe, i != 0);
        end
        apb(1, 12'h2C4, 0);
        apb(1, 12'h2CC, 32'h10);
        apb(1, 12'h2D0, 32'h10);
        for (i = 0; i < 20; i++) run_row(ROWS[i]);
        // Refused places leave registers alone
        apb(1, 12'h3FC, 32'hFF);
        check("err_unmapped", e, 1);
        check("ready", pready, 1);
        apb(1, 12'h2C1, 32'hFF);
        check("err_misaligned", e, 1);
        apb(0, 12'h2C0, 0);
        check("ctrl_a_kept", d, 0);
        apb(0, 12'h2CC, 0);
        check("cmp_a_buf", d, 32'h10);
        apb(1, 12'h2C4, 0);
        apb(1, 12'h2E4, 1);
        #1;
        check("ovf_clear", ovf, 0);
        wrap_up;
    end
endmodule
